// ===== hw/sisr_top.sv
/*
  Status bank with write-one-to-clear update flags for a switch monitor: matrix comparison bits for
  sense inputs 14 and 15, and packed 10-bit conversion results of inputs 0..9,
  reached over an AHB-Lite slave port with zero wait states.
  Assumes the converter and comparator logic run on hclk and deliver one-cycle
  update strobes; the slave is the only one on its bus.
*/
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps

module sisr_top #(
	parameter int unsigned RESULT_W = sisr_pkg::RESULT_W,
	parameter int unsigned NUM_PAIRS = sisr_pkg::NUM_PAIRS
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave port
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata_ff,
	output logic hreadyout_ff,
	output logic hresp_ff,
	// Result producers on the same clock
	input wire sisr_pkg::sisr_conv_update_t conv_update,
	input wire sisr_pkg::sisr_matrix_update_t matrix_update
);

	// Layout below is fixed to ten-bit fields and five pairs
	if (RESULT_W != sisr_pkg::RESULT_W || NUM_PAIRS != sisr_pkg::NUM_PAIRS) begin : g_bad_cfg
		$error("sisr_top supports only ten-bit results in five pairs");
	end

	// Stored fields of every result pair
	logic [RESULT_W-1:0] lo_val [NUM_PAIRS];
	logic [RESULT_W-1:0] hi_val [NUM_PAIRS];
	// Write strobes toward the pairs
	logic [NUM_PAIRS-1:0] wr_lo;
	logic [NUM_PAIRS-1:0] wr_hi;
	// Channel decode of the incoming conversion
	logic ch_ok;
	logic [2:0] ch_pair;
	logic ch_odd;

	// Matrix comparison bits
	logic [sisr_pkg::MAT_W-1:0] sense15_ff;
	logic [sisr_pkg::MAT_W-1:0] sense14_ff;

	// Sticky update flags and their clear path
	logic [sisr_pkg::NUM_FLAGS-1:0] upd_flags_ff;
	logic [sisr_pkg::NUM_FLAGS-1:0] flag_set;
	logic [sisr_pkg::NUM_FLAGS-1:0] flag_clr;

	// Bus address phase decode
	logic xfer_ok;
	logic [sisr_pkg::IDX_W-1:0] a_idx;
	// Pending write remembered for the data phase
	logic wr_pend_ff;
	logic [sisr_pkg::IDX_W-1:0] wr_idx_ff;
	// Word selected by the current read address
	logic [31:0] nxt_rdata;

	// Which pair and which half a conversion lands in
	always_comb begin
		ch_ok = conv_update.valid && (conv_update.channel <= sisr_pkg::MAX_CHANNEL);
		ch_pair = conv_update.channel[3:1];
		ch_odd = conv_update.channel[0];
	end

	// Even channel to the low field, odd channel to the high field
	for (genvar k = 0; k < NUM_PAIRS; k++) begin : g_pair
		// Channels 2k and 2k+1 share register index 0xA+k
		assign wr_lo[k] = ch_ok && (ch_pair == 3'(k)) && !ch_odd;
		assign wr_hi[k] = ch_ok && (ch_pair == 3'(k)) && ch_odd;

		// One stored register per pair, reset to zero
		sisr_result_pair #(
			.W(RESULT_W)
		) u_pair (
			.hclk(hclk),
			.hresetn(hresetn),
			.wr_lo(wr_lo[k]),
			.wr_hi(wr_hi[k]),
			.din(conv_update.value),
			.lo_ff(lo_val[k]),
			.hi_ff(hi_val[k])
		);
	end

	// Matrix snapshot; only a new comparison pass replaces it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sense15_ff <= '0;
			sense14_ff <= '0;
		end else if (matrix_update.valid) begin
			// Sense 15 pass results
			sense15_ff <= matrix_update.sense15;
			// Sense 14 pass results
			sense14_ff <= matrix_update.sense14;
		end
	end

	// Flag sources: one per pair, plus the matrix snapshot
	always_comb begin
		flag_set = '0;
		for (int unsigned k = 0; k < NUM_PAIRS; k++) begin
			flag_set[k] = wr_lo[k] || wr_hi[k];
		end
		flag_set[sisr_pkg::FLAG_MATRIX] = matrix_update.valid;
	end

	// Write-one-to-clear on the flag register during a write data phase
	always_comb begin
		flag_clr = '0;
		if (wr_pend_ff && (wr_idx_ff == sisr_pkg::IDX_UPDATE_FLAGS)) begin
			flag_clr = hwdata[sisr_pkg::NUM_FLAGS-1:0];
		end
	end

	// Sticky flags; a fresh result in the clearing cycle keeps its flag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			upd_flags_ff <= '0;
		end else begin
			upd_flags_ff <= (upd_flags_ff & ~flag_clr) | flag_set;
		end
	end

	// A transfer is taken when selected, active and the bus is ready
	always_comb begin
		xfer_ok = hsel && htrans[sisr_pkg::HTRANS_ACTIVE_BIT] && hready;
		a_idx = haddr[sisr_pkg::BYTE_SHIFT +: sisr_pkg::IDX_W];
	end

	// Remember a write so its data phase can be acted on
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_idx_ff <= '0;
		end else begin
			wr_pend_ff <= xfer_ok && hwrite;
			wr_idx_ff <= a_idx;
		end
	end

	// Builds one analog result word; reserved top bits stay zero
	function automatic logic [31:0] pack_pair(
		input logic [RESULT_W-1:0] hi,
		input logic [RESULT_W-1:0] lo
	);
		logic [31:0] w;
		w = sisr_pkg::WORD_ZERO;
		// Low channel LSB at bit 0, MSB at bit 9
		w[sisr_pkg::LO_LSB +: RESULT_W] = lo;
		// High channel LSB at bit 10, MSB at bit 19
		w[sisr_pkg::HI_LSB +: RESULT_W] = hi;
		// Bits 23:20 are written with zero here; the unused top byte is never written
		w[sisr_pkg::RSVD_LSB +: sisr_pkg::RSVD_W] = '0;
		return w;
	endfunction

	// Read decode; a pure multiplexer, so a read cannot disturb any field
	always_comb begin
		nxt_rdata = sisr_pkg::WORD_ZERO;
		unique case (a_idx)
			sisr_pkg::IDX_MATRIX_UPPER: begin
				// Comparator bits 23:12 belong to another block and read zero
				nxt_rdata[sisr_pkg::MAT15_LSB +: sisr_pkg::MAT_W] = sense15_ff;
				nxt_rdata[sisr_pkg::MAT14_LSB +: sisr_pkg::MAT_W] = sense14_ff;
			end
			sisr_pkg::IDX_ANA_0_1: begin
				nxt_rdata = pack_pair(hi_val[0], lo_val[0]);
			end
			sisr_pkg::IDX_ANA_2_3: begin
				nxt_rdata = pack_pair(hi_val[1], lo_val[1]);
			end
			sisr_pkg::IDX_ANA_4_5: begin
				nxt_rdata = pack_pair(hi_val[2], lo_val[2]);
			end
			sisr_pkg::IDX_ANA_6_7: begin
				nxt_rdata = pack_pair(hi_val[3], lo_val[3]);
			end
			sisr_pkg::IDX_ANA_8_9: begin
				// Exists from reset with all fields zero
				nxt_rdata = pack_pair(hi_val[4], lo_val[4]);
			end
			sisr_pkg::IDX_UPDATE_FLAGS: begin
				nxt_rdata[sisr_pkg::NUM_FLAGS-1:0] = upd_flags_ff;
			end
			default: begin
				// Unmapped addresses read zero with an OKAY answer
				nxt_rdata = sisr_pkg::WORD_ZERO;
			end
		endcase
	end

	// Read data is captured at the address phase edge, so no wait state is needed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= sisr_pkg::WORD_ZERO;
		end else if (xfer_ok && !hwrite) begin
			hrdata_ff <= nxt_rdata;
		end else begin
			// Writes to status fields fall through here and change nothing
			hrdata_ff <= sisr_pkg::WORD_ZERO;
		end
	end

	// Always ready after reset; every access completes in one data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_ff <= 1'b0;
		end else begin
			hreadyout_ff <= 1'b1;
		end
	end

	// The bank never raises an error, even on unmapped or odd-sized access
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp_ff <= sisr_pkg::HRESP_OKAY;
		end else begin
			hresp_ff <= sisr_pkg::HRESP_OKAY;
		end
	end

endmodule

// ===== hw/sisr_pkg.sv
/*
  Shared constants and carrier types for the switch input status readback bank.
  Assumes a single 50 MHz register clock domain and an AHB-Lite register bus
  with 32-bit data, one aligned word per register.
*/
package sisr_pkg;

	// Bus and register widths
	localparam int unsigned BUS_W = 32;
	localparam int unsigned REG_W = 24;
	localparam int unsigned IDX_W = 8;
	localparam int unsigned BYTE_SHIFT = 2;

	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_MATRIX_UPPER = 8'h09;
	localparam logic [7:0] IDX_ANA_0_1 = 8'h0A;
	localparam logic [7:0] IDX_ANA_2_3 = 8'h0B;
	localparam logic [7:0] IDX_ANA_4_5 = 8'h0C;
	localparam logic [7:0] IDX_ANA_6_7 = 8'h0D;
	localparam logic [7:0] IDX_ANA_8_9 = 8'h0E;
	localparam logic [7:0] IDX_UPDATE_FLAGS = 8'h20;

	// Conversion result layout inside an analog result register
	localparam int unsigned RESULT_W = 10;
	localparam int unsigned NUM_PAIRS = 5;
	localparam int unsigned LO_LSB = 0;
	localparam int unsigned HI_LSB = 10;
	localparam int unsigned RSVD_LSB = 20;
	localparam int unsigned RSVD_W = 4;
	localparam logic [3:0] MAX_CHANNEL = 4'h9;

	// Matrix comparison layout inside the upper matrix register
	localparam int unsigned MAT_W = 6;
	localparam int unsigned MAT14_LSB = 0;
	localparam int unsigned MAT15_LSB = 6;

	// Update flag register layout: one bit per result pair, then the matrix bit
	localparam int unsigned NUM_FLAGS = 6;
	localparam int unsigned FLAG_MATRIX = 5;

	// Reset values
	localparam logic [23:0] REG_RESET = 24'h000000;
	localparam logic [31:0] WORD_ZERO = 32'h00000000;

	// AHB-Lite encodings
	localparam int unsigned HTRANS_ACTIVE_BIT = 1;
	localparam logic HRESP_OKAY = 1'h0;

	// New conversion result from the converter sequencer
	typedef struct packed {
		logic valid;
		logic [3:0] channel;
		logic [9:0] value;
	} sisr_conv_update_t;

	// New matrix comparison snapshot; bit k of each vector is drive input k+4
	typedef struct packed {
		logic valid;
		logic [5:0] sense15;
		logic [5:0] sense14;
	} sisr_matrix_update_t;

endpackage

// ===== hw/sisr_result_pair.sv
/*
  One analog result register: two conversion fields held in flip-flops.
  Assumes write strobes come from logic on the same clock and are one cycle long.
*/
`timescale 1ns/1ps

module sisr_result_pair #(
	parameter int unsigned W = 10
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Update side
	input wire logic wr_lo,
	input wire logic wr_hi,
	input wire logic [W-1:0] din,
	// Stored fields
	output logic [W-1:0] lo_ff,
	output logic [W-1:0] hi_ff
);

	// Even channel field; only a fresh conversion changes it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lo_ff <= '0;
		end else if (wr_lo) begin
			lo_ff <= din;
		end
	end

	// Odd channel field
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hi_ff <= '0;
		end else if (wr_hi) begin
			hi_ff <= din;
		end
	end

endmodule

// ===== bench/sisr_top_props.sv
/*
  Checker for the status bank: bus answers and field placement.
  Assumes hready is tied to hreadyout_ff.
*/
`timescale 1ns/1ps

module sisr_top_props #(
	parameter int unsigned RESULT_W = 10,
	parameter int unsigned NUM_PAIRS = 5
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata_ff,
	input wire logic hreadyout_ff,
	input wire logic hresp_ff,
	// Producers
	input wire sisr_pkg::sisr_conv_update_t conv_update,
	input wire sisr_pkg::sisr_matrix_update_t matrix_update
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Read address phase taken at this edge
	wire rd_t = hsel && htrans[1] && hready && !hwrite;
	wire [7:0] idx = haddr[9:2];
	wire cv = conv_update.valid;
	wire mv = matrix_update.valid;
	// Fresh result, then a read of its register at once: odd channels sit high
	property p_cv(logic [3:0] c, logic [7:0] i);
		(cv && conv_update.channel == c) ##1 (rd_t && idx == i && !cv) |=>
		(c[0] ? hrdata_ff[19:10] : hrdata_ff[9:0]) == $past(conv_update.value, 2);
	endproperty
	chk_resp_okay: assert property (hresp_ff == 1'h0) else $error("resp");
	// Ready is up from the second edge after release, so no access can stall
	chk_ready_up: assert property ($past(hresetn) |-> hreadyout_ff) else $error("ready");
	chk_cv_ch0: assert property (p_cv(4'h0, 8'h0A)) else $error("ch0");
	chk_cv_ch1: assert property (p_cv(4'h1, 8'h0A)) else $error("ch1");
	chk_cv_ch3: assert property (p_cv(4'h3, 8'h0B)) else $error("ch3");
	chk_cv_ch4: assert property (p_cv(4'h4, 8'h0C)) else $error("ch4");
	chk_cv_ch7: assert property (p_cv(4'h7, 8'h0D)) else $error("ch7");
	chk_cv_ch9: assert property (p_cv(4'h9, 8'h0E)) else $error("ch9");
	chk_rsvd_zero: assert property (rd_t && idx >= 8'h0A && idx <= 8'h0E |=>
		hrdata_ff[31:20] == 12'h000) else $error("reserved bits");
	chk_matrix_bits: assert property (mv ##1 (rd_t && idx == 8'h09 && !mv) |=>
		hrdata_ff == {20'h00000, $past(matrix_update.sense15, 2),
		$past(matrix_update.sense14, 2)}) else $error("matrix bits");
	// Main scenarios
	cover property (rd_t && idx == 8'h0E);
	cover property (mv);
	cover property (hsel && htrans[1] && hwrite);
endmodule

bind sisr_top sisr_top_props #(.RESULT_W(RESULT_W), .NUM_PAIRS(NUM_PAIRS)) u_sisr_top_props (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
	.hrdata_ff, .hreadyout_ff, .hresp_ff, .conv_update, .matrix_update);

// ===== bench/sisr_host_model.sv
/*
  Host bus master model: single word transfers on AHB-Lite.
  Assumes one slave whose hreadyout drives hready.
*/
`timescale 1ns/1ps

module sisr_host_model (
	// Clock and ready
	input wire logic hclk,
	input wire logic hready,
	// Bus requests
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	// Set when a wait runs out
	output logic tmo
);
	// Idle bus at time zero
	initial {hsel, haddr, htrans, hwrite, hsize, hwdata, tmo} = '0;
	// Address phase held until hready, then data phase held until hready
	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
		int n = 0;
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		htrans <= 2'h2;
		do begin
			@(posedge hclk);
			n++;
		end while (!hready && n < 64);
		htrans <= 2'h0;
		hwdata <= d;
		do begin
			@(posedge hclk);
			n++;
		end while (!hready && n < 128);
		// Released data is inverted so a stale value cannot pass
		hwdata <= ~d;
		if (!hready) tmo <= 1'b1;
	endtask
endmodule

// ===== bench/tb_switch_input_status_readback.sv
/*
  Self-checking bench for the status bank: feeds results, reads them back.
  Assumes the host model drives the bus and the checker is bound in.
*/
`timescale 1ns/1ps

module tb_switch_input_status_readback;
	// Clock, reset and bus wires
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel, hwrite, hreadyout_ff, hresp_ff, tmo;
	logic [31:0] haddr, hwdata, hrdata_ff;
	logic [1:0] htrans;
	logic [2:0] hsize;
	// Producer inputs, idle at time zero
	sisr_pkg::sisr_conv_update_t cv = '0;
	sisr_pkg::sisr_matrix_update_t mv = '0;
	// Expected read data and bookkeeping
	logic [31:0] exp_q[$];
	int error_cnt = 0;
	int compares = 0;
	logic rd_ph = 1'b0;
	// Fields not yet written by a scenario are zero, as after reset
	logic [9:0] val[10] = '{default: 10'h000};
	logic [11:0] mat;
	int i;

	initial forever #10 hclk = ~hclk;

	sisr_top u_sisr_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout_ff), .hrdata_ff, .hreadyout_ff, .hresp_ff,
		.conv_update(cv), .matrix_update(mv));
	sisr_host_model u_sisr_host_model (.hclk, .hready(hreadyout_ff), .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .tmo);

	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task end_sim;
		// Expected words never compared count as mismatches
		error_cnt += exp_q.size();
		$display("errors=%0d compares=%0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Reads note their expected word before the request goes out
	task rd(input logic [31:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		u_sisr_host_model.xfer(a, 1'b0, 32'h0);
	endtask

	// Expected packed pair k: odd channel high, even channel low
	function automatic logic [31:0] pk(int k);
		return {12'h000, val[2 * k + 1], val[2 * k]};
	endfunction

	// One-cycle result strobe
	task conv(input int c, input logic [9:0] v);
		@(posedge hclk);
		cv <= {1'b1, 4'(c), v};
		@(posedge hclk);
		cv <= '0;
	endtask

	// The data phase after a taken read carries the answer
	always @(posedge hclk) begin
		if (rd_ph && exp_q.size() > 0) check(hrdata_ff, exp_q.pop_front());
		rd_ph <= hsel && htrans[1] && hreadyout_ff && !hwrite;
	end

	// A wait that ran out ends the run
	always @(posedge tmo) begin
		error_cnt++;
		end_sim;
	end

	initial begin
		void'($urandom(32'h35BC));
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		// The matrix and analog result registers and one unmapped index read zero after reset
		for (i = 9; i < 16; i++) rd(4 * i, 32'h0);
		// Each channel lands in its own field, read straight after the strobe
		for (i = 0; i < 10; i++) begin
			val[i] = 10'($urandom);
			conv(i, val[i]);
			rd(32'h28 + 4 * (i / 2), pk(i / 2));
		end
		// Matrix snapshot
		mat = 12'($urandom);
		@(posedge hclk);
		mv <= {1'b1, mat};
		@(posedge hclk);
		mv <= '0;
		rd(32'h24, {20'h0, mat});
		// A channel above nine is dropped; the reads below find every pair intact
		conv(10 + ($urandom % 6), 10'($urandom));
		// Writes change nothing, and a repeated read sees the same word
		for (i = 9; i < 15; i++) begin
			u_sisr_host_model.xfer(4 * i, 1'b1, $urandom);
			rd(4 * i, (i == 9) ? {20'h0, mat} : pk(i - 10));
			rd(4 * i, (i == 9) ? {20'h0, mat} : pk(i - 10));
		end
		// Flag register saw all five pairs and the matrix; write-one clears them
		rd(32'h80, 32'h3F);
		u_sisr_host_model.xfer(32'h80, 1'b1, 32'h3F);
		rd(32'h80, 32'h0);
		// Reset in mid-run returns every field and flag to zero
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		for (i = 9; i < 15; i++) rd(4 * i, 32'h0);
		rd(32'h80, 32'h0);
		@(posedge hclk);
		end_sim;
	end
endmodule
